// ===== inc/csr_consts.svh
// Purpose: constants of the card suspend / resume handler
// Assumes: bytes are 8 bits, durations are unit byte then count byte
// Notes: status words are sw1 in [15:8], sw2 in [7:0]
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

`define CSR_P1_SUSPEND 8'h00
`define CSR_P1_RESUME 8'h01
`define CSR_P2_ZERO 8'h00
`define CSR_SUSP_LC 8'h04
`define CSR_SUSP_LE 8'h0a
`define CSR_RES_LC 8'h08
`define CSR_SELECT_BY_NAME 8'h04

`define CSR_SW_OK 16'h9000
`define CSR_SW_NOT_ALLOWED 16'h6985
`define CSR_SW_DUR_TOO_BIG 16'h9864
`define CSR_SW_TOKEN_BAD 16'h6982
`define CSR_SW_BAD_P1P2 16'h6a86
`define CSR_SW_BAD_LEN 16'h6700
`define CSR_SW_BAD_DATA 16'h6a80

`define CSR_UNIT_SEC 8'h00
`define CSR_UNIT_MIN 8'h01
`define CSR_UNIT_HOUR 8'h02
`define CSR_UNIT_DAY 8'h03
`define CSR_UNIT_TENDAY 8'h04

`define CSR_SECS_MIN 28'h3c
`define CSR_SECS_HOUR 28'he10
`define CSR_SECS_DAY 28'h15180
`define CSR_SECS_TENDAY 28'hd2f00

`define CSR_TOKEN_BYTES 4'h8
`define CSR_RSP_BYTES 4'ha
`define CSR_LFSR_SEED 64'h0123_4567_89ab_cdef

`endif

// ===== inc/csr_pkg.sv
// Purpose: types shared by the suspend / resume handler and its users
// Assumes: the command decoder ahead of this block classifies commands
// Notes: none
package csr_pkg;
   typedef enum logic [2:0] {
      CSR_CMD_SUSPEND,
      CSR_CMD_SELECT,
      CSR_CMD_READ_BINARY,
      CSR_CMD_READ_RECORD,
      CSR_CMD_TERM_CAP,
      CSR_CMD_OTHER
   } csr_cmd_e;

   typedef enum logic [2:0] {
      CSR_IDLE,
      CSR_RX,
      CSR_CHECK,
      CSR_SAVE,
      CSR_RESTORE,
      CSR_RSP,
      CSR_SW
   } csr_state_e;
endpackage

// ===== hw/csr_token_gen.sv
// Purpose: free-running 64-bit pseudo random source for resume tokens
// Assumes: i_entropy toggles from some noisy source, may be tied low
// Notes: output is registered
`timescale 1ns/10ps
`include "csr_consts.svh"
module csr_token_gen (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_entropy,
   output logic [63:0] o_token
);
   logic fb;

   // taps 64,63,61,60; entropy mixed in so tokens differ per power-up
   assign fb = o_token[63] ^ o_token[62] ^ o_token[60] ^ o_token[59]
               ^ i_entropy;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_token <= `CSR_LFSR_SEED;
      end else begin
         o_token <= {o_token[62:0], fb};
      end
   end
endmodule

// ===== hw/csr_ctrl.sv
// Purpose: card-side handler of the suspend and resume command pair
// Assumes: header and data bytes arrive pre-parsed from a frame decoder
// Notes: session state itself lives in an external store driven here
//
// Overview of operation
// - refuse suspend 6985 while proactive, bearer channel or secure use
// - suspend may also be refused 6985 for internal reasons
// - refuse suspend 9864 when proposed minimum exceeds card capability
// - accepted suspend saves random 8-byte token with full state
// - negotiated maximum lies between proposed minimum and maximum
// - no pending-proactive status after a successful suspend
// - suspend uses P1 00, P2 00, four data bytes, ten reply bytes
// - reply holds negotiated maximum then the eight token bytes
// - durations are a unit byte then a count byte
// - resume erases saved state on success and on token mismatch
// - only some read commands allowed before resume
// - any other command erases saved state and continues
// - resume without valid saved state is refused 6985
// - token mismatch on resume answers 6982
// - token match restores saved state and answers 9000
// - resume uses P1 01, P2 00, eight token bytes, no reply data
`timescale 1ns/10ps
`include "csr_consts.svh"
module csr_ctrl (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire csr_pkg::csr_cmd_e i_cmd_kind,
   input wire logic [7:0] i_p1,
   input wire logic [7:0] i_p2,
   input wire logic [7:0] i_lc,
   input wire logic i_le_present,
   input wire logic [7:0] i_le,
   input wire logic i_data_valid,
   input wire logic [7:0] i_data,
   input wire logic i_proactive_active,
   input wire logic i_bearer_channel_open,
   input wire logic i_secure_channel_active,
   input wire logic i_internal_refuse,
   input wire logic [15:0] i_card_max_dur,
   input wire logic i_entropy,
   input wire logic i_store_done,
   output logic o_busy,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_data,
   output logic o_sw_valid,
   output logic [15:0] o_sw,
   output logic o_save_req,
   output logic o_restore_req,
   output logic o_erase_req,
   output logic o_saved_valid,
   output logic o_hold_proactive,
   output logic [63:0] o_saved_token
);
   import csr_pkg::*;

   csr_state_e state;
   csr_state_e next_state;
   logic [7:0] hdr_p1;
   logic [7:0] hdr_p2;
   logic [7:0] hdr_lc;
   logic hdr_le_present;
   logic [7:0] hdr_le;
   logic [7:0] rx_cnt;
   logic [63:0] rx_buf;
   logic [3:0] rsp_idx;
   logic [15:0] neg_dur;
   logic [15:0] next_sw;
   logic [63:0] rand_token;
   logic cmd_take;
   logic rx_last;
   logic pre_resume_ok;
   logic [15:0] prop_min;
   logic [15:0] prop_max;
   logic [27:0] min_secs;
   logic [27:0] max_secs;
   logic [27:0] card_secs;
   logic units_ok;
   logic accept_susp;
   logic token_match;
   logic start_resume;
   logic [7:0] rsp_byte;

   csr_token_gen u_token (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_entropy(i_entropy),
      .o_token(rand_token)
   );

   // duration in seconds, wide enough for 255 ten-day periods
   function automatic logic [27:0] dur_secs(input logic [15:0] d);
      logic [27:0] cnt;
      cnt = {20'h0, d[7:0]};
      case (d[15:8])
         `CSR_UNIT_SEC: dur_secs = cnt;
         `CSR_UNIT_MIN: dur_secs = 28'(cnt * `CSR_SECS_MIN);
         `CSR_UNIT_HOUR: dur_secs = 28'(cnt * `CSR_SECS_HOUR);
         `CSR_UNIT_DAY: dur_secs = 28'(cnt * `CSR_SECS_DAY);
         `CSR_UNIT_TENDAY: dur_secs = 28'(cnt * `CSR_SECS_TENDAY);
         default: dur_secs = 28'h0;
      endcase
   endfunction

   assign cmd_take = i_cmd_valid && !o_busy;
   assign rx_last = i_data_valid && (rx_cnt + 8'h01 == hdr_lc);

   // reads allowed before resume; SELECT by name is not among them
   always_comb begin
      case (i_cmd_kind)
         CSR_CMD_SELECT: pre_resume_ok = (i_p1 != `CSR_SELECT_BY_NAME);
         CSR_CMD_READ_BINARY: pre_resume_ok = 1'b1;
         CSR_CMD_READ_RECORD: pre_resume_ok = 1'b1;
         CSR_CMD_TERM_CAP: pre_resume_ok = 1'b1;
         default: pre_resume_ok = 1'b0;
      endcase
   end

   // first data byte sits in rx_buf[31:24] for a four-byte field
   assign prop_min = rx_buf[31:16];
   assign prop_max = rx_buf[15:0];
   assign min_secs = dur_secs(prop_min);
   assign max_secs = dur_secs(prop_max);
   assign card_secs = dur_secs(i_card_max_dur);
   assign units_ok = (prop_min[15:8] <= `CSR_UNIT_TENDAY)
                     && (prop_max[15:8] <= `CSR_UNIT_TENDAY)
                     && (min_secs <= max_secs);
   assign token_match = (rx_buf == o_saved_token);

   // verdict of the checking cycle
   always_comb begin
      next_sw = `CSR_SW_OK;
      accept_susp = 1'b0;
      start_resume = 1'b0;
      if (hdr_p1 == `CSR_P1_SUSPEND) begin
         if (hdr_p2 != `CSR_P2_ZERO) begin
            next_sw = `CSR_SW_BAD_P1P2;
         end else if (hdr_lc != `CSR_SUSP_LC || !hdr_le_present
                      || hdr_le != `CSR_SUSP_LE) begin
            next_sw = `CSR_SW_BAD_LEN;
         end else if (!units_ok) begin
            next_sw = `CSR_SW_BAD_DATA;
         end else if (i_proactive_active || i_bearer_channel_open
                      || i_secure_channel_active) begin
            next_sw = `CSR_SW_NOT_ALLOWED;
         end else if (i_internal_refuse) begin
            next_sw = `CSR_SW_NOT_ALLOWED;
         end else if (min_secs > card_secs) begin
            next_sw = `CSR_SW_DUR_TOO_BIG;
         end else begin
            accept_susp = 1'b1;
         end
      end else if (hdr_p1 == `CSR_P1_RESUME) begin
         if (hdr_p2 != `CSR_P2_ZERO) begin
            next_sw = `CSR_SW_BAD_P1P2;
         end else if (hdr_lc != `CSR_RES_LC || hdr_le_present) begin
            next_sw = `CSR_SW_BAD_LEN;
         end else if (!o_saved_valid) begin
            next_sw = `CSR_SW_NOT_ALLOWED;
         end else if (!token_match) begin
            next_sw = `CSR_SW_TOKEN_BAD;
         end else begin
            start_resume = 1'b1;
         end
      end else begin
         next_sw = `CSR_SW_BAD_P1P2;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         CSR_IDLE: begin
            if (cmd_take && i_cmd_kind == CSR_CMD_SUSPEND) begin
               next_state = (i_lc == 8'h00) ? CSR_CHECK : CSR_RX;
            end
         end
         CSR_RX: begin
            if (rx_last) begin
               next_state = CSR_CHECK;
            end
         end
         CSR_CHECK: begin
            if (accept_susp) begin
               next_state = CSR_SAVE;
            end else if (start_resume) begin
               next_state = CSR_RESTORE;
            end else begin
               next_state = CSR_SW;
            end
         end
         CSR_SAVE: begin
            if (i_store_done) begin
               next_state = CSR_RSP;
            end
         end
         CSR_RESTORE: begin
            if (i_store_done) begin
               next_state = CSR_SW;
            end
         end
         CSR_RSP: begin
            if (rsp_idx == `CSR_RSP_BYTES - 4'd1) begin
               next_state = CSR_SW;
            end
         end
         CSR_SW: next_state = CSR_IDLE;
         default: next_state = CSR_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state <= CSR_IDLE;
         o_busy <= 1'b0;
      end else begin
         state <= next_state;
         o_busy <= (next_state != CSR_IDLE);
      end
   end

   // header latch and data byte collection
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         hdr_p1 <= 8'h00;
         hdr_p2 <= 8'h00;
         hdr_lc <= 8'h00;
         hdr_le_present <= 1'b0;
         hdr_le <= 8'h00;
         rx_cnt <= 8'h00;
         rx_buf <= 64'h0;
      end else if (state == CSR_IDLE && cmd_take) begin
         hdr_p1 <= i_p1;
         hdr_p2 <= i_p2;
         hdr_lc <= i_lc;
         hdr_le_present <= i_le_present;
         hdr_le <= i_le;
         rx_cnt <= 8'h00;
         rx_buf <= 64'h0;
      end else if (state == CSR_RX && i_data_valid) begin
         // only the last eight bytes survive an overlong field
         rx_cnt <= rx_cnt + 8'h01;
         rx_buf <= {rx_buf[55:0], i_data};
      end
   end

   // negotiated maximum: terminal max clipped to what the card can do
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         neg_dur <= 16'h0;
      end else if (state == CSR_CHECK && accept_susp) begin
         neg_dur <= (card_secs >= max_secs) ? prop_max
                                            : i_card_max_dur;
      end
   end

   // saved-state flag and token; cleared by reset, so lost at a fresh card session
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_saved_valid <= 1'b0;
         o_saved_token <= 64'h0;
      end else if (state == CSR_CHECK && accept_susp) begin
         o_saved_token <= rand_token;
      end else if (state == CSR_SAVE && i_store_done) begin
         o_saved_valid <= 1'b1;
      end else if (state == CSR_CHECK && hdr_p1 == `CSR_P1_RESUME
                   && next_sw == `CSR_SW_TOKEN_BAD) begin
         o_saved_valid <= 1'b0;
      end else if (state == CSR_RESTORE && i_store_done) begin
         o_saved_valid <= 1'b0;
      end else if (state == CSR_IDLE && cmd_take && o_saved_valid
                   && i_cmd_kind != CSR_CMD_SUSPEND
                   && !pre_resume_ok) begin
         o_saved_valid <= 1'b0;
      end
   end

   // strobes to the session store
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_save_req <= 1'b0;
         o_restore_req <= 1'b0;
         o_erase_req <= 1'b0;
      end else begin
         o_save_req <= (state == CSR_CHECK) && accept_susp;
         // restore brings back the pre-suspend context, dropping reads
         o_restore_req <= (state == CSR_CHECK) && start_resume;
         o_erase_req <= ((state == CSR_CHECK)
                         && hdr_p1 == `CSR_P1_RESUME
                         && next_sw == `CSR_SW_TOKEN_BAD)
                        || ((state == CSR_RESTORE) && i_store_done)
                        || ((state == CSR_IDLE) && cmd_take
                            && o_saved_valid
                            && i_cmd_kind != CSR_CMD_SUSPEND
                            && !pre_resume_ok);
      end
   end

   // once suspended the card waits for power-down, no new proactive
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_hold_proactive <= 1'b0;
      end else if (state == CSR_SAVE && i_store_done) begin
         o_hold_proactive <= 1'b1;
      end else if (state == CSR_RESTORE && i_store_done) begin
         o_hold_proactive <= 1'b0;
      end
   end

   always_comb begin
      case (rsp_idx)
         4'd0: rsp_byte = neg_dur[15:8];
         4'd1: rsp_byte = neg_dur[7:0];
         default: rsp_byte = o_saved_token[8'd63 - {rsp_idx - 4'd2, 3'b000}
                                           -: 8];
      endcase
   end

   // reply bytes: negotiated duration then token, msb byte first
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rsp_idx <= 4'd0;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= 8'h00;
      end else if (state == CSR_RSP) begin
         rsp_idx <= rsp_idx + 4'd1;
         o_rsp_valid <= 1'b1;
         o_rsp_data <= rsp_byte;
      end else begin
         rsp_idx <= 4'd0;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= 8'h00;
      end
   end

   // status word; held until the next one
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_sw_valid <= 1'b0;
         o_sw <= 16'h0;
      end else begin
         o_sw_valid <= (state == CSR_SW);
         if (state == CSR_CHECK && !accept_susp && !start_resume) begin
            o_sw <= next_sw;
         end else if (state == CSR_CHECK) begin
            o_sw <= `CSR_SW_OK;
         end
      end
   end
endmodule

// ===== tb/csr_ctrl_monitor.sv
// Purpose: port assertions for the suspend / resume handler
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every csr_ctrl instance
`timescale 1ns/10ps
`include "csr_consts.svh"
module csr_ctrl_monitor (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire csr_pkg::csr_cmd_e i_cmd_kind,
   input wire logic i_proactive_active,
   input wire logic i_bearer_channel_open,
   input wire logic i_secure_channel_active,
   input wire logic i_internal_refuse,
   input wire logic i_store_done,
   input wire logic o_busy,
   input wire logic o_rsp_valid,
   input wire logic o_sw_valid,
   input wire logic [15:0] o_sw,
   input wire logic o_save_req,
   input wire logic o_restore_req,
   input wire logic o_erase_req,
   input wire logic o_saved_valid,
   input wire logic o_hold_proactive
);
   import csr_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic scr;
   // header screened against a pending saved state
   assign scr = i_cmd_valid && !o_busy && o_saved_valid;

   property p_no_save;
      o_save_req |-> !($past(i_proactive_active) || $past(i_internal_refuse)
         || $past(i_bearer_channel_open) || $past(i_secure_channel_active));
   endproperty
   a_no_save: assert property (p_no_save)
      else $error("suspend accepted while refusal set");
   property p_rsp_len;
      $rose(o_rsp_valid) |-> o_rsp_valid[*8] ##1 o_rsp_valid[*2]
         ##1 !o_rsp_valid;
   endproperty
   a_rsp_len: assert property (p_rsp_len)
      else $error("reply is not ten bytes");
   property p_rsp_sw;
      $fell(o_rsp_valid) |-> o_sw_valid && o_sw == `CSR_SW_OK;
   endproperty
   a_rsp_sw: assert property (p_rsp_sw)
      else $error("reply not closed by ok status");
   property p_valid_set;
      $rose(o_saved_valid) |-> $past(i_store_done);
   endproperty
   a_valid_set: assert property (p_valid_set)
      else $error("saved flag set without store done");
   property p_hold;
      $rose(o_hold_proactive) |-> o_saved_valid;
   endproperty
   a_hold: assert property (p_hold)
      else $error("proactive hold without saved state");
   property p_erase;
      o_erase_req |=> !o_saved_valid;
   endproperty
   a_erase: assert property (p_erase)
      else $error("saved flag survives erase");
   property p_restore;
      o_restore_req |-> ##[2:20] o_erase_req ##1
         (o_sw_valid && o_sw == `CSR_SW_OK);
   endproperty
   a_restore: assert property (p_restore)
      else $error("restore not followed by erase and ok");
   property p_other;
      scr && i_cmd_kind == CSR_CMD_OTHER |=> o_erase_req;
   endproperty
   a_other: assert property (p_other)
      else $error("foreign command did not erase");
   property p_allowed;
      scr && i_cmd_kind inside {CSR_CMD_READ_BINARY, CSR_CMD_READ_RECORD,
         CSR_CMD_TERM_CAP} |=> !o_erase_req && o_saved_valid;
   endproperty
   a_allowed: assert property (p_allowed)
      else $error("allowed command erased saved state");
   property p_idle;
      o_sw_valid |-> !o_busy;
   endproperty
   a_idle: assert property (p_idle)
      else $error("busy after status");
endmodule

bind csr_ctrl csr_ctrl_monitor i_mon (.i_mclk, .i_rst, .i_cmd_valid,
   .i_cmd_kind, .i_proactive_active, .i_bearer_channel_open,
   .i_secure_channel_active, .i_internal_refuse, .i_store_done, .o_busy,
   .o_rsp_valid, .o_sw_valid, .o_sw, .o_save_req, .o_restore_req,
   .o_erase_req, .o_saved_valid, .o_hold_proactive);

// ===== tb/csr_store_model.sv
// Purpose: session store answering save and restore requests
// Assumes: requests are one-cycle pulses
// Notes: i_slow stretches the answer, as a slow memory would
`timescale 1ns/10ps
module csr_store_model (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_save_req,
   input wire logic i_restore_req,
   input wire logic i_slow,
   output logic o_store_done
);
   int cnt;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 0;
         o_store_done <= 1'h0;
      end else begin
         o_store_done <= (cnt == 1);
         if (i_save_req || i_restore_req) begin
            cnt <= i_slow ? 6 : 1;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the suspend / resume handler
// Assumes: inputs change at the falling clock edge
// Notes: power_on models a fresh card session
`timescale 1ns/10ps
module tb_top;
   import csr_pkg::*;
   logic i_mclk = 1'h0;
   logic i_rst = 1'h1;
   logic i_cmd_valid = 1'h0;
   logic i_le_present = 1'h0;
   logic i_data_valid = 1'h0;
   logic slow = 1'h0;
   csr_cmd_e i_cmd_kind = CSR_CMD_OTHER;
   logic [7:0] i_p1 = 8'h00, i_p2 = 8'h00, i_lc = 8'h00;
   logic [7:0] i_le = 8'h00, i_data = 8'h00;
   logic [3:0] refuse = 4'h0;
   logic i_proactive_active, i_bearer_channel_open;
   logic i_secure_channel_active, i_internal_refuse;
   logic [15:0] i_card_max_dur = 16'h0201;
   logic i_store_done, o_busy, o_rsp_valid, o_sw_valid, o_save_req;
   logic o_restore_req, o_erase_req, o_saved_valid, o_hold_proactive;
   logic [7:0] o_rsp_data;
   logic [15:0] o_sw;
   logic [63:0] o_saved_token;
   logic [79:0] rx;
   // card max, proposed min, proposed max, negotiated
   logic [15:0] tab [4][4] = '{'{16'h0201, 16'h000a, 16'h0105, 16'h0105},
      '{16'h003c, 16'h0001, 16'h0105, 16'h003c},
      '{16'h0201, 16'h0002, 16'h0401, 16'h0201},
      '{16'h0301, 16'h0202, 16'h0302, 16'h0301}};
   int error_cnt = 0, checked = 0, cyc = 0, nrsp;

   assign {i_proactive_active, i_bearer_channel_open,
      i_secure_channel_active, i_internal_refuse} = refuse;

   csr_ctrl i_dut (.i_mclk, .i_rst, .i_cmd_valid, .i_cmd_kind, .i_p1, .i_p2,
      .i_lc, .i_le_present, .i_le, .i_data_valid, .i_data,
      .i_proactive_active, .i_bearer_channel_open, .i_secure_channel_active,
      .i_internal_refuse, .i_card_max_dur, .i_entropy(1'h0), .i_store_done,
      .o_busy, .o_rsp_valid, .o_rsp_data, .o_sw_valid, .o_sw, .o_save_req,
      .o_restore_req, .o_erase_req, .o_saved_valid, .o_hold_proactive,
      .o_saved_token);
   csr_store_model i_sm (.i_mclk, .i_rst, .i_save_req(o_save_req),
      .i_restore_req(o_restore_req), .i_slow(slow),
      .o_store_done(i_store_done));

   always #5 i_mclk = ~i_mclk;

   task finish_test;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test;
      end
   end

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
      end
   endtask

   task power_on;
      i_rst = 1'h1;
      repeat (6) @(negedge i_mclk);
      i_rst = 1'h0;
   endtask

   // data bytes leave from the top of d, one per cycle
   task cmd(input csr_cmd_e k, input logic [7:0] p1, input logic [7:0] p2,
      input logic [7:0] lc, input logic lep, input logic [63:0] d);
      @(negedge i_mclk);
      while (o_busy !== 1'h0) @(negedge i_mclk);
      {i_cmd_valid, i_cmd_kind, i_p1, i_p2, i_lc} = {1'h1, k, p1, p2, lc};
      {i_le_present, i_le} = {lep, 8'h0a};
      @(negedge i_mclk);
      i_cmd_valid = 1'h0;
      for (int n = 0; n < lc; n++) begin
         i_data_valid = 1'h1;
         i_data = d[63 - 8 * n -: 8];
         @(negedge i_mclk);
      end
      i_data_valid = 1'h0;
   endtask

   task wait_sw;
      nrsp = 0;
      repeat (100) begin
         @(posedge i_mclk);
         #1;
         if (o_rsp_valid === 1'h1) begin
            rx = {rx[71:0], o_rsp_data};
            nrsp++;
         end
         if (o_sw_valid === 1'h1) begin
            // hand back at the falling edge, where inputs may change
            @(negedge i_mclk);
            return;
         end
      end
      chk(1'h0, 1'h1);
   endtask

   task susp(input logic [31:0] d);
      // single-interface terminal, card has declared support
      cmd(CSR_CMD_SUSPEND, 8'h00, 8'h00, 8'h04, 1'h1, {d, 32'h0});
      wait_sw;
   endtask

   task resm(input logic [63:0] t);
      cmd(CSR_CMD_SUSPEND, 8'h01, 8'h00, 8'h08, 1'h0, t);
      wait_sw;
   endtask

   task screen(input csr_cmd_e k, input logic [7:0] p1);
      cmd(k, p1, 8'h00, 8'h00, 1'h0, 64'h0);
      repeat (3) @(negedge i_mclk);
   endtask

   task t_accept;
      for (int r = 0; r < 4; r++) begin
         power_on;
         slow = r[0];
         i_card_max_dur = tab[r][0];
         susp({tab[r][1], tab[r][2]});
         chk(o_sw, 16'h9000);
         chk(nrsp, 10);
         chk(rx[79:64], tab[r][3]);
         chk(rx[63:0], o_saved_token);
         chk({o_saved_valid, o_hold_proactive}, 2'h3);
      end
      i_card_max_dur = 16'h0201;
   endtask

   task t_refuse;
      power_on;
      for (int f = 0; f < 4; f++) begin
         refuse = 4'h1 << f;
         susp(32'h000a_0105);
         chk(o_sw, 16'h6985);
      end
      refuse = 4'h0;
      i_card_max_dur = 16'h0001;
      susp(32'h0002_0105);
      chk(o_sw, 16'h9864);
      i_card_max_dur = 16'h0201;
      cmd(CSR_CMD_SUSPEND, 8'h00, 8'h00, 8'h03, 1'h1, 64'h0);
      wait_sw;
      chk(o_sw, 16'h6700);
      cmd(CSR_CMD_SUSPEND, 8'h01, 8'h01, 8'h08, 1'h0, 64'h0);
      wait_sw;
      chk(o_sw, 16'h6a86);
      susp(32'h0500_0105);
      chk(o_sw, 16'h6a80);
      susp(32'h0105_000a);
      chk(o_sw, 16'h6a80);
      cmd(CSR_CMD_SUSPEND, 8'h01, 8'h00, 8'h08, 1'h1, 64'h0);
      wait_sw;
      chk(o_sw, 16'h6700);
      cmd(CSR_CMD_SUSPEND, 8'h02, 8'h00, 8'h00, 1'h0, 64'h0);
      wait_sw;
      chk(o_sw, 16'h6a86);
      chk(o_saved_valid, 1'h0);
   endtask

   task t_resume;
      logic [63:0] t;
      for (int m = 0; m < 2; m++) begin
         power_on;
         screen(CSR_CMD_TERM_CAP, 8'h00);
         susp(32'h0001_0105);
         t = rx[63:0];
         // contacts off and on again; no reset, saved state is kept
         repeat (4) @(negedge i_mclk);
         screen(CSR_CMD_TERM_CAP, 8'h00);
         screen(CSR_CMD_SELECT, 8'h02);
         screen(CSR_CMD_READ_BINARY, 8'h00);
         screen(CSR_CMD_READ_RECORD, 8'h00);
         chk(o_saved_valid, 1'h1);
         resm(t ^ 64'(m));
         chk(o_sw, m ? 16'h6982 : 16'h9000);
         chk(o_saved_valid, 1'h0);
         resm(t);
         chk(o_sw, 16'h6985);
      end
   endtask

   task t_other;
      for (int k = 0; k < 2; k++) begin
         power_on;
         susp(32'h0001_0105);
         screen(k ? CSR_CMD_OTHER : CSR_CMD_SELECT, 8'h04);
         chk(o_saved_valid, 1'h0);
         resm(rx[63:0]);
         chk(o_sw, 16'h6985);
      end
   endtask

   initial begin
      power_on;
      t_accept;
      t_refuse;
      t_resume;
      t_other;
      finish_test;
   end
endmodule
